/* hdl/ifm_top.sv */
// Top of the non-vectored normal and fast interrupt mask and status logic.
`timescale 1ns/1ps
`default_nettype none
module ifm_top
    import ifm_pkg::*;
(
    input  wire logic          sys_clk_i,
    input  wire logic          rst_i,
    input  wire logic [31:0]   addr_i,
    input  wire logic [DW-1:0] wr_data_i,
    input  wire logic          wr_stb_i,
    input  wire logic          rd_stb_i,
    output logic      [DW-1:0] rd_data_o,
    input  wire logic [DW-1:0] normal_src_i,
    input  wire logic [DW-1:0] fast_src_i,
    output logic               normal_interrupt_request_o,
    output logic               fast_interrupt_request_o
);

    // -------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------
    typedef struct packed {
        logic          prog_norm;
        logic          prog_fast;
        logic          norm_req;
        logic          fast_req;
        logic [DW-1:0] rdata;
    } ifm_top_st_t;

    ifm_top_st_t st_q;
    ifm_top_st_t st_d;

    logic [DW-1:0] norm_sync;
    logic [DW-1:0] fast_sync;
    logic [DW-1:0] norm_raw;
    logic [DW-1:0] fast_raw;
    logic [DW-1:0] norm_sta;
    logic [DW-1:0] fast_sta;
    logic [DW-1:0] prog_word;
    logic          fast_or;
    ifm_sel_t      wsel;
    ifm_sel_t      rsel;

    ifm_mask_if mif ();

    // -------------------------------------------------------------------
    // Source synchronisers
    // -------------------------------------------------------------------
    ifm_src_sync u_norm_sync (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .src_i     (normal_src_i),
        .src_o     (norm_sync)
    );

    ifm_src_sync u_fast_sync (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .src_i     (fast_src_i),
        .src_o     (fast_sync)
    );

    // -------------------------------------------------------------------
    // Enable masks
    // -------------------------------------------------------------------
    ifm_mask_pair u_masks (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .mif       (mif.mask)
    );

    assign wsel         = ifm_decode(addr_i);
    assign rsel         = ifm_decode(addr_i);
    assign mif.wdata    = wr_data_i;
    assign mif.norm_set = wr_stb_i && (wsel == SEL_NEN);
    assign mif.norm_clr = wr_stb_i && (wsel == SEL_NCLR);
    assign mif.fast_set = wr_stb_i && (wsel == SEL_FEN);
    assign mif.fast_clr = wr_stb_i && (wsel == SEL_FCLR);

    // -------------------------------------------------------------------
    // Raw source and status words
    // -------------------------------------------------------------------
    // Bit 0 carries the fast OR and bit 1 the programmed source on both
    // lines; the remaining bits follow the synchronised peripherals.
    // Bit 1 of status ignores the mask so programmed requests always fire.
    always_comb begin
        fast_raw                = fast_sync;
        fast_raw[PROG_SRC_BIT]  = st_q.prog_fast;
        fast_raw[FAST_OR_BIT]   = 1'b0;
        fast_sta                = ifm_masked(fast_raw, mif.fast_en);
        fast_sta[PROG_SRC_BIT]  = st_q.prog_fast;
        fast_sta[FAST_OR_BIT]   = 1'b0;
        fast_or                 = |fast_sta[DW-1:1];
        fast_raw[FAST_OR_BIT]   = fast_or;
        fast_sta[FAST_OR_BIT]   = fast_or & mif.fast_en[FAST_OR_BIT];
        norm_raw                = norm_sync;
        norm_raw[PROG_SRC_BIT]  = st_q.prog_norm;
        norm_raw[FAST_OR_BIT]   = fast_or;
        norm_sta                = ifm_masked(norm_raw, mif.norm_en);
        norm_sta[PROG_SRC_BIT]  = st_q.prog_norm;
    end

    always_comb begin
        prog_word                = RST_WORD;
        prog_word[PROG_NORM_BIT] = st_q.prog_norm;
        prog_word[PROG_FAST_BIT] = st_q.prog_fast;
    end

    // -------------------------------------------------------------------
    // Register updates, read path and request outputs
    // -------------------------------------------------------------------
    // Only the OR of the status words reaches the core; which source is
    // served is left to software.
    always_comb begin
        st_d          = st_q;
        st_d.norm_req = |norm_sta;
        st_d.fast_req = fast_or;
        if (wr_stb_i && (wsel == SEL_PROG)) begin
            st_d.prog_norm = wr_data_i[PROG_NORM_BIT];
            st_d.prog_fast = wr_data_i[PROG_FAST_BIT];
        end
        st_d.rdata = RST_WORD;
        if (rd_stb_i) begin
            unique case (rsel)
                SEL_NSTA: st_d.rdata = norm_sta;
                SEL_NRAW: st_d.rdata = norm_raw;
                SEL_NEN:  st_d.rdata = mif.norm_en;
                SEL_PROG: st_d.rdata = prog_word;
                SEL_FSTA: st_d.rdata = fast_sta;
                SEL_FRAW: st_d.rdata = fast_raw;
                SEL_FEN:  st_d.rdata = mif.fast_en;
                SEL_NCLR: st_d.rdata = RST_WORD;
                SEL_FCLR: st_d.rdata = RST_WORD;
                SEL_NONE: st_d.rdata = RST_WORD;
                default:  st_d.rdata = RST_WORD;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign rd_data_o                  = st_q.rdata;
    assign normal_interrupt_request_o = st_q.norm_req;
    assign fast_interrupt_request_o   = st_q.fast_req;

endmodule : ifm_top
`default_nettype wire

/* hdl/ifm_pkg.sv */
// Constants, register map and helper functions for the interrupt mask logic.
//
// Functional notes
// - A normal request other than programmed bit 1 reaches the core only while its normal mask bit is 1.
// - Writing zero to the normal mask never disables a source.
// - Normal clear is write-only; each 1 bit clears that normal mask bit.
// - Fast status bits 31..1 ORed drive fast request and bit 0 of raw.
// - A 1 written to the fast mask clears the same normal mask bit.
// - A 1 written to the normal mask clears the same fast mask bit.
// - A source may be disabled in both masks at once.
// - Fast raw bits follow their peripheral interrupt signals.
// - Fast mask 1 enables, 0 blocks; writing zeros never disables.
// - Fast clear is write-only; each 1 bit clears that fast mask bit.
// - Fast status bits other than bit 1 are fast raw AND fast mask.
// - No priority encoding and no vector; software picks the source.
// - Programmed bit 2 sets or clears bit 1 of fast status and raw.
// - Programmed bit 1 sets or clears bit 1 of normal status and raw.
// - Programmed interrupts bypass the masks and write status and raw together.
// - Fast registers are 32 bits and map sources like the normal ones.
// - All 32 normal status bits ORed form the normal request.
// - Normal raw bits follow their peripheral interrupt signals.
package ifm_pkg;

    localparam int unsigned DW = 32;

    // -------------------------------------------------------------------
    // Register byte addresses
    // -------------------------------------------------------------------
    localparam logic [31:0] ADR_NORMAL_STATUS = 32'hffff_0000;
    localparam logic [31:0] ADR_NORMAL_RAW    = 32'hffff_0004;
    localparam logic [31:0] ADR_NORMAL_EN     = 32'hffff_0008;
    localparam logic [31:0] ADR_NORMAL_CLR    = 32'hffff_000c;
    localparam logic [31:0] ADR_PROG_CFG      = 32'hffff_0010;
    localparam logic [31:0] ADR_FAST_STATUS   = 32'hffff_0100;
    localparam logic [31:0] ADR_FAST_RAW      = 32'hffff_0104;
    localparam logic [31:0] ADR_FAST_EN       = 32'hffff_0108;
    localparam logic [31:0] ADR_FAST_CLR      = 32'hffff_010c;

    // -------------------------------------------------------------------
    // Field positions and reset values
    // -------------------------------------------------------------------
    localparam int unsigned    FAST_OR_BIT   = 0;
    localparam int unsigned    PROG_SRC_BIT  = 1;
    localparam int unsigned    PROG_NORM_BIT = 1;
    localparam int unsigned    PROG_FAST_BIT = 2;
    localparam logic [DW-1:0]  RST_WORD      = 32'h0000_0000;
    localparam int unsigned    SYNC_STAGES   = 3;

    typedef enum logic [3:0] {
        SEL_NONE   = 4'b0000,
        SEL_NSTA   = 4'b0001,
        SEL_NRAW   = 4'b0010,
        SEL_NEN    = 4'b0011,
        SEL_NCLR   = 4'b0100,
        SEL_PROG   = 4'b0101,
        SEL_FSTA   = 4'b0110,
        SEL_FRAW   = 4'b0111,
        SEL_FEN    = 4'b1000,
        SEL_FCLR   = 4'b1001
    } ifm_sel_t;

    // Address decode shared by the read and the write path.
    function automatic ifm_sel_t ifm_decode(input logic [31:0] adr);
        ifm_sel_t sel;
        sel = SEL_NONE;
        unique case (adr)
            ADR_NORMAL_STATUS: sel = SEL_NSTA;
            ADR_NORMAL_RAW:    sel = SEL_NRAW;
            ADR_NORMAL_EN:     sel = SEL_NEN;
            ADR_NORMAL_CLR:    sel = SEL_NCLR;
            ADR_PROG_CFG:      sel = SEL_PROG;
            ADR_FAST_STATUS:   sel = SEL_FSTA;
            ADR_FAST_RAW:      sel = SEL_FRAW;
            ADR_FAST_EN:       sel = SEL_FEN;
            ADR_FAST_CLR:      sel = SEL_FCLR;
            default:           sel = SEL_NONE;
        endcase
        return sel;
    endfunction : ifm_decode

    // Masked status of one line; the caller overrides bit 1, and bit 0 on the fast line only.
    function automatic logic [DW-1:0] ifm_masked(input logic [DW-1:0] raw,
                                                 input logic [DW-1:0] en);
        return raw & en;
    endfunction : ifm_masked

endpackage : ifm_pkg

/* hdl/ifm_mask_if.sv */
// Interface carrying mask write events and mask values between modules.
`timescale 1ns/1ps
`default_nettype none
interface ifm_mask_if;
    logic        norm_set;
    logic        norm_clr;
    logic        fast_set;
    logic        fast_clr;
    logic [31:0] wdata;
    logic [31:0] norm_en;
    logic [31:0] fast_en;

    modport ctrl (output norm_set, norm_clr, fast_set, fast_clr, wdata,
                  input  norm_en, fast_en);
    modport mask (input  norm_set, norm_clr, fast_set, fast_clr, wdata,
                  output norm_en, fast_en);
endinterface : ifm_mask_if
`default_nettype wire

/* hdl/ifm_src_sync.sv */
// Three-stage synchroniser with agreement filter for the source inputs.
`timescale 1ns/1ps
`default_nettype none
module ifm_src_sync
    import ifm_pkg::*;
(
    input  wire logic          sys_clk_i,
    input  wire logic          rst_i,
    input  wire logic [DW-1:0] src_i,
    output logic      [DW-1:0] src_o
);
    typedef struct packed {
        logic [DW-1:0] s1;
        logic [DW-1:0] s2;
        logic [DW-1:0] s3;
        logic [DW-1:0] val;
    } ifm_sync_st_t;

    ifm_sync_st_t st_q;
    ifm_sync_st_t st_d;

    // A bit takes the new level only once stages two and three agree.
    always_comb begin
        st_d     = st_q;
        st_d.s1  = src_i;
        st_d.s2  = st_q.s1;
        st_d.s3  = st_q.s2;
        st_d.val = (st_q.s2 & ~(st_q.s2 ^ st_q.s3))
                 | (st_q.val & (st_q.s2 ^ st_q.s3));
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign src_o = st_q.val;
endmodule : ifm_src_sync
`default_nettype wire

/* hdl/ifm_mask_pair.sv */
// Normal and fast enable masks with set, clear and mutual exclusion.
`timescale 1ns/1ps
`default_nettype none
module ifm_mask_pair
    import ifm_pkg::*;
(
    input  wire logic sys_clk_i,
    input  wire logic rst_i,
    ifm_mask_if.mask  mif
);
    typedef struct packed {
        logic [DW-1:0] norm_en;
        logic [DW-1:0] fast_en;
    } ifm_mask_st_t;

    ifm_mask_st_t st_q;
    ifm_mask_st_t st_d;

    // Zeros written to a mask leave it alone; clear registers and ones written to the other mask disable.
    always_comb begin
        st_d = st_q;
        if (mif.norm_set) begin
            st_d.norm_en = st_q.norm_en | mif.wdata;
            st_d.fast_en = st_q.fast_en & ~mif.wdata;
        end
        if (mif.norm_clr) begin
            st_d.norm_en = st_q.norm_en & ~mif.wdata;
        end
        if (mif.fast_set) begin
            st_d.fast_en = st_q.fast_en | mif.wdata;
            st_d.norm_en = st_q.norm_en & ~mif.wdata;
        end
        if (mif.fast_clr) begin
            st_d.fast_en = st_q.fast_en & ~mif.wdata;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign mif.norm_en = st_q.norm_en;
    assign mif.fast_en = st_q.fast_en;
endmodule : ifm_mask_pair
`default_nettype wire

/* dv/ifm_top_assertions.sv */
// Checker for the register port and request outputs of the mask logic.
`timescale 1ns/1ps
`default_nettype none
module ifm_checker
    import ifm_pkg::*;
(
    input  wire logic          sys_clk_i,
    input  wire logic          rst_i,
    input  wire logic [31:0]   addr_i,
    input  wire logic [DW-1:0] wr_data_i,
    input  wire logic          wr_stb_i,
    input  wire logic          rd_stb_i,
    input  wire logic [DW-1:0] rd_data_o,
    input  wire logic [DW-1:0] normal_src_i,
    input  wire logic [DW-1:0] fast_src_i,
    input  wire logic          normal_interrupt_request_o,
    input  wire logic          fast_interrupt_request_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);

    logic [31:0] nm_q;
    logic [31:0] fm_q;
    logic [2:1]  pg_q;

    // Shadow of both masks and the programmed bits, built from the writes.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            nm_q <= '0;
            fm_q <= '0;
            pg_q <= '0;
        end else if (wr_stb_i) begin
            case (addr_i)
                ADR_NORMAL_EN:
                    {nm_q, fm_q} <= {nm_q | wr_data_i, fm_q & ~wr_data_i};
                ADR_FAST_EN:
                    {nm_q, fm_q} <= {nm_q & ~wr_data_i, fm_q | wr_data_i};
                ADR_NORMAL_CLR: nm_q <= nm_q & ~wr_data_i;
                ADR_FAST_CLR:   fm_q <= fm_q & ~wr_data_i;
                ADR_PROG_CFG:   pg_q <= wr_data_i[2:1];
                default: ;
            endcase
        end
    end

    nmask_read_a:
        assert property (rd_stb_i && addr_i == ADR_NORMAL_EN |=> rd_data_o == nm_q)
        else $error("normal mask reads wrong");
    fmask_read_a:
        assert property (rd_stb_i && addr_i == ADR_FAST_EN |=> rd_data_o == fm_q)
        else $error("fast mask reads wrong");
    clear_reads_zero_a:
        assert property (rd_stb_i && (addr_i == ADR_NORMAL_CLR ||
            addr_i == ADR_FAST_CLR) |=> rd_data_o == '0)
        else $error("clear register not write-only");
    prog_read_a:
        assert property (rd_stb_i && addr_i == ADR_PROG_CFG |=>
            rd_data_o == {29'h0, pg_q, 1'b0})
        else $error("programmed bits read wrong");
    fsta_masked_a:
        assert property (rd_stb_i && addr_i == ADR_FAST_STATUS |=>
            (rd_data_o[31:2] & ~fm_q[31:2]) == '0 && rd_data_o[1] == pg_q[2])
        else $error("fast status not masked");
    nsta_masked_a:
        assert property (rd_stb_i && addr_i == ADR_NORMAL_STATUS |=>
            (rd_data_o[31:2] & ~nm_q[31:2]) == '0 && rd_data_o[1] == pg_q[1])
        else $error("normal status not masked");
    fast_req_or_a:
        assert property (rd_stb_i && addr_i == ADR_FAST_STATUS |=>
            fast_interrupt_request_o == |rd_data_o[31:1])
        else $error("fast request differs from status");
    norm_req_or_a:
        assert property (rd_stb_i && addr_i == ADR_NORMAL_STATUS |=>
            normal_interrupt_request_o == |rd_data_o)
        else $error("normal request differs from status");
    // A source level seen on two edges in a row reaches raw two edges on.
    fraw_follows_a:
        assert property (rd_stb_i && addr_i == ADR_FAST_RAW &&
            $past(fast_src_i, 3) == $past(fast_src_i, 4) |=>
            rd_data_o[31:2] == $past(fast_src_i[31:2], 4))
        else $error("fast raw does not follow sources");
    nraw_follows_a:
        assert property (rd_stb_i && addr_i == ADR_NORMAL_RAW &&
            $past(normal_src_i, 3) == $past(normal_src_i, 4) |=>
            rd_data_o[31:2] == $past(normal_src_i[31:2], 4))
        else $error("normal raw does not follow sources");
endmodule : ifm_checker

bind ifm_top ifm_checker u_chk (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_stb_i(wr_stb_i), .rd_stb_i(rd_stb_i),
    .rd_data_o(rd_data_o), .normal_src_i(normal_src_i),
    .fast_src_i(fast_src_i),
    .normal_interrupt_request_o(normal_interrupt_request_o),
    .fast_interrupt_request_o(fast_interrupt_request_o)
);
`default_nettype wire

/* dv/ifm_core_model.sv */
// Behavioural processor core that takes the normal and fast requests.
`timescale 1ns/1ps
`default_nettype none
module ifm_core_model (
    input  wire logic       sys_clk_i,
    input  wire logic       rst_i,
    input  wire logic       normal_req_i,
    input  wire logic       fast_req_i,
    output logic      [1:0] mode_o
);
    // The core enters fast mode rather than normal mode when both are raised.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            mode_o <= 2'h0;
        end else begin
            mode_o <= fast_req_i ? 2'h2 : {1'b0, normal_req_i};
        end
    end
endmodule : ifm_core_model
`default_nettype wire

/* dv/ifm_top_bench.sv */
// Self-checking bench for the interrupt mask and status logic.
`timescale 1ns/1ps
`default_nettype none
module ifm_top_bench
    import ifm_pkg::*;
;
    localparam logic [31:0] ADRS [10] = '{ADR_NORMAL_STATUS, ADR_NORMAL_RAW,
        ADR_NORMAL_EN, ADR_NORMAL_CLR, ADR_PROG_CFG, ADR_FAST_STATUS,
        ADR_FAST_RAW, ADR_FAST_EN, ADR_FAST_CLR, 32'hffff_0014};
    localparam logic [31:0] WADRS [6] = '{ADR_NORMAL_CLR, ADR_FAST_CLR,
        ADR_NORMAL_EN, ADR_FAST_EN, ADR_PROG_CFG, 32'hffff_0014};
    logic        sys_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [31:0] addr_i = '0;
    logic [31:0] wr_data_i = '0;
    logic        wr_stb_i = 1'b0;
    logic        rd_stb_i = 1'b0;
    logic [31:0] normal_src_i = '0;
    logic [31:0] fast_src_i = '0;
    logic [31:0] rd_data_o;
    logic        nreq;
    logic        freq;
    logic [1:0]  mode;
    logic [31:0] nm = '0;
    logic [31:0] fm = '0;
    logic [2:1]  pg = '0;
    logic [31:0] rng = 32'h0000_9d80;
    int          error_cnt = 0;
    int          compares = 0;

    always #12.5 sys_clk_i = ~sys_clk_i;

    ifm_top DUT (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i),
        .wr_data_i(wr_data_i), .wr_stb_i(wr_stb_i), .rd_stb_i(rd_stb_i),
        .rd_data_o(rd_data_o), .normal_src_i(normal_src_i),
        .fast_src_i(fast_src_i), .normal_interrupt_request_o(nreq),
        .fast_interrupt_request_o(freq));
    ifm_core_model u_core (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .normal_req_i(nreq), .fast_req_i(freq), .mode_o(mode));

    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction : xs

    // Expected register value; source bits 1 and 0 are not inputs.
    function automatic logic [31:0] exp_val(input logic [31:0] a);
        logic [31:0] fr;
        logic [31:0] nr;
        logic [31:0] fs;
        logic        fo;
        fr = fast_src_i & 32'hffff_fffc;
        nr = normal_src_i & 32'hffff_fffc;
        fs = (fr & fm) | {29'h0, pg[2], 1'b0};
        fo = |fs[31:1];
        case (a)
            ADR_NORMAL_STATUS:
                return (nr & nm) | {29'h0, pg[1], 1'b0} | {31'h0, fo & nm[0]};
            ADR_NORMAL_RAW: return nr | {29'h0, pg[1], fo};
            ADR_NORMAL_EN:  return nm;
            ADR_PROG_CFG:   return {29'h0, pg, 1'b0};
            ADR_FAST_STATUS: return fs | {31'h0, fo & fm[0]};
            ADR_FAST_RAW:   return fr | {29'h0, pg[2], fo};
            ADR_FAST_EN:    return fm;
            default:        return 32'h0;
        endcase
    endfunction : exp_val

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic end_of_test();
        if (error_cnt == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test

    task automatic rd(input logic [31:0] a, output logic [31:0] v);
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_stb_i <= 1'b1;
        @(posedge sys_clk_i);
        rd_stb_i <= 1'b0;
        #1 v = rd_data_o;
    endtask : rd

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        addr_i <= a;
        wr_data_i <= d;
        wr_stb_i <= 1'b1;
        @(posedge sys_clk_i);
        wr_stb_i <= 1'b0;
        case (a)
            ADR_NORMAL_EN: {nm, fm} = {nm | d, fm & ~d};
            ADR_FAST_EN:   {nm, fm} = {nm & ~d, fm | d};
            ADR_NORMAL_CLR: nm = nm & ~d;
            ADR_FAST_CLR:  fm = fm & ~d;
            ADR_PROG_CFG:  pg = d[2:1];
            default: ;
        endcase
    endtask : wr

    task automatic sweep();
        logic [31:0] v;
        logic [31:0] e;
        repeat (8) @(posedge sys_clk_i);
        for (int i = 0; i < 10; i++) begin
            rd(ADRS[i], v);
            chk(v, exp_val(ADRS[i]));
        end
        e = exp_val(ADR_FAST_STATUS);
        v = exp_val(ADR_NORMAL_STATUS);
        chk({31'h0, freq}, {31'h0, |e[31:1]});
        chk({31'h0, nreq}, {31'h0, |v});
        chk({30'h0, mode}, {30'h0, |e[31:1] ? 2'h2 : {1'b0, |v}});
    endtask : sweep

    // Sources change first and settle before any clear, as software would.
    task automatic step(input logic [31:0] a, input logic [31:0] d,
                        input logic [31:0] ns, input logic [31:0] fs);
        @(posedge sys_clk_i);
        normal_src_i <= ns;
        fast_src_i <= fs;
        repeat (8) @(posedge sys_clk_i);
        wr(a, d);
        sweep();
    endtask : step

    initial begin
        int k;
        repeat (16) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        sweep();
        step(ADR_NORMAL_EN, 32'hffff_ffff, 32'h0, 32'h0);
        step(ADR_FAST_EN, 32'h0000_0000, '1, '1);
        step(ADR_NORMAL_EN, 32'h0000_0000, '1, '1);
        step(ADR_FAST_EN, 32'h8000_0021, '1, '1);
        step(ADR_PROG_CFG, 32'hffff_ffff, '1, 32'h0);
        step(ADR_NORMAL_CLR, 32'hffff_ffff, 32'h0, 32'h0);
        step(ADR_FAST_CLR, 32'hffff_ffff, 32'h0, 32'h0);
        step(ADR_PROG_CFG, 32'h0000_0000, '1, '1);
        for (int i = 0; i < 60; i++) begin
            k = int'(xs() % 6);
            step(WADRS[k], xs(), k < 2 ? 32'h0 : xs(), k < 2 ? 32'h0 : xs());
        end
        end_of_test();
    end

    // Cut a hang short at about fifteen times the expected run length.
    initial begin
        #1_000_000;
        error_cnt++;
        end_of_test();
    end
endmodule : ifm_top_bench
`default_nettype wire
